// *** shared/psc_pkg.sv ***
package psc_pkg;

    // geometry
    localparam int          NPORT     = 10;
    localparam int          NWORD     = 16;
    localparam int          NFLD      = 30;
    localparam int          MEM_DEPTH = NPORT * NWORD;
    localparam logic [3:0]  LAST_PORT = 4'h9;
    localparam logic [3:0]  LAST_WORD = 4'hf;

    // register map, byte addresses
    localparam logic [11:0] A_CTRL    = 12'h400;
    localparam logic [11:0] A_WRAP_LO = 12'h404;
    localparam logic [11:0] A_WRAP_HI = 12'h408;
    localparam int          CTRL_EN_B = 0;
    localparam logic        CTRL_RST  = 1'h1;

    // wrapped-status word layout
    localparam int          WRAP_LSB  = 0;
    localparam int          LPORT_LSB = 30;

    // named counter fields; only tx bytes, rx bytes and total rx bytes add a byte count
    localparam int          F_TX_BYTES  = 0;
    localparam int          F_SEND_FAIL = 2;
    localparam int          F_RX_BYTES  = 5;
    localparam int          F_RX_TOTB   = 7;
    localparam int          F_FILTER    = 27;
    localparam int          F_DLY_DISC  = 28;
    localparam int          F_LATE_COL  = 29;

    // field table, bit 29 first down to bit 0
    localparam logic [NFLD-1:0][3:0] FLD_WORD = {
        4'hf, 4'hf, 4'hf, 4'he, 4'he, 4'hd, 4'hd, 4'hc, 4'hc, 4'hc,
        4'hb, 4'hb, 4'ha, 4'ha, 4'h9, 4'h9, 4'h8, 4'h8, 4'h7, 4'h7,
        4'h6, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h2, 4'h1, 4'h1, 4'h0};
    localparam logic [NFLD-1:0][4:0] FLD_LSB = {
        5'h18, 5'h10, 5'h00, 5'h10, 5'h00, 5'h10, 5'h00, 5'h18, 5'h10, 5'h00,
        5'h10, 5'h00, 5'h10, 5'h00, 5'h18, 5'h00, 5'h18, 5'h00, 5'h10, 5'h00,
        5'h18, 5'h00, 5'h00, 5'h00, 5'h00, 5'h10, 5'h00, 5'h18, 5'h00, 5'h00};
    localparam logic [NFLD-1:0][5:0] FLD_WID = {
        6'h08, 6'h08, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h08, 6'h08, 6'h10,
        6'h10, 6'h10, 6'h10, 6'h10, 6'h08, 6'h18, 6'h08, 6'h18, 6'h10, 6'h10,
        6'h08, 6'h18, 6'h20, 6'h20, 6'h20, 6'h10, 6'h10, 6'h08, 6'h18, 6'h20};

    typedef enum logic [1:0] {S_CLR, S_IDLE, S_RD, S_WR} psc_state_t;

endpackage

// *** shared/psc_mem_if.sv ***
`timescale 1ns/1ns
interface psc_mem_if;
    logic [7:0]  upd_addr;
    logic [31:0] upd_rdata;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic        host_rd;
    logic [7:0]  host_addr;
    logic        alt_sel;
    logic [31:0] alt_data;
    logic [31:0] host_rdata;

    modport ctl (output upd_addr, wr_en, wr_addr, wr_data, host_rd, host_addr, alt_sel,
                 alt_data, input upd_rdata, host_rdata);
    modport mem (input upd_addr, wr_en, wr_addr, wr_data, host_rd, host_addr, alt_sel,
                 alt_data, output upd_rdata, host_rdata);
endinterface

// *** hw/psc_mem.sv ***
`timescale 1ns/1ns
module psc_mem (
    // clock, reset, enable
    input logic  mclk,
    input logic  rst_n,
    input logic  ce,
    // access ports
    psc_mem_if.mem m
);

    logic [31:0] ram [0:psc_pkg::MEM_DEPTH-1];
    logic [31:0] upd_rdata_r;
    logic [31:0] host_rdata_r;

    always_ff @(posedge mclk) begin
        if (ce && m.wr_en) begin
            ram[m.wr_addr] <= m.wr_data;
        end
    end

    // status reads share the host data register so every read answers in one cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            upd_rdata_r  <= 32'h0;
            host_rdata_r <= 32'h0;
        end else if (ce) begin
            upd_rdata_r <= ram[m.upd_addr];
            if (m.host_rd) begin
                host_rdata_r <= m.alt_sel ? m.alt_data : ram[m.host_addr];
            end
        end
    end

    assign m.upd_rdata  = upd_rdata_r;
    assign m.host_rdata = host_rdata_r;

endmodule

// *** hw/psc_top.sv ***
`timescale 1ns/1ns
// Overview of operation
// - each port keeps its own counter set, readable by the host CPU
// - counters roll over to zero and keep counting, never saturate
// - any rollover raises the interrupt so software can total long-term
// - MAC feeds most events; buffer manager delay discards; queue manager filtering
// - 64-bit wrap word: bits 29..0 wrap flags, bits 63..30 other status
// - flags 0..4: tx bytes, unicast sent, send fail, pause sent, non-unicast
// - flags 5..8: rx bytes, rx frames, total rx bytes, total rx frames
// - flags 9..11: pause rx, multicast rx, broadcast rx in words 6, 7
// - flags 12..16: 64B, jabber, 65-127B, oversize, 128-255B frames
// - flags 17..19: 256-511, 512-1023, 1024-1528 buckets, 16-bit in words A, B
// - flags 20..29: fragments through late collisions in fixed order
// - full-word counters: word 0 and words 3 to 5
// - 24-bit counters sit in bits 23..0
// - upper 8-bit counters sit in bits 31..24
// - middle 8-bit counters sit in bits 23..16
// - lower 16-bit counters sit in bits 15..0
// - upper 16-bit counters sit in bits 31..16
// - send fail counts underrun, late collision, or sixteen collisions
// - length buckets count both good and bad frames
module psc_top (
    // clock and reset
    input  logic        mclk,
    input  logic        rst_n,
    input  logic        ce,
    // register port
    input  logic [11:0] reg_addr,
    input  logic [31:0] reg_wdata,
    input  logic        reg_wr,
    input  logic        reg_rd,
    output logic [31:0] reg_rdata,
    // mac events
    input  logic        mac_evt_vld,
    input  logic [3:0]  mac_evt_port,
    input  logic [29:0] mac_evt_inc,
    input  logic [15:0] mac_tx_bytes,
    input  logic [15:0] mac_rx_bytes,
    input  logic        mac_tx_underrun,
    input  logic        mac_late_col,
    input  logic        mac_col16,
    output logic        mac_evt_rdy,
    // buffer and queue manager discards
    input  logic        bm_dly_vld,
    input  logic [3:0]  bm_dly_port,
    input  logic        qm_filt_vld,
    input  logic [3:0]  qm_filt_port,
    // wrap status to the command block
    output logic [63:0] wrap_word,
    output logic        wrap_irq
);

    psc_mem_if mif ();

    psc_pkg::psc_state_t st_r, st_nxt;
    logic [3:0]          port_r, port_nxt;
    logic [3:0]          word_r, word_nxt;
    logic [29:0]         inc_r, inc_nxt;
    logic [15:0]         txb_r, txb_nxt;
    logic [15:0]         rxb_r, rxb_nxt;
    logic                rdy_r, rdy_nxt;
    logic [9:0]          pend_filt_r, pend_filt_nxt;
    logic [9:0]          pend_dly_r, pend_dly_nxt;
    logic [29:0]         flags_r, flags_nxt;
    logic [3:0]          lport_r, lport_nxt;
    logic                ctrl_en_r, ctrl_en_nxt;
    logic                irq_r, irq_nxt;
    logic [29:0]         wrap_now;
    logic [31:0]         upd_word;
    logic [9:0]          pend_any;
    logic [3:0]          pend_port;
    logic                cnt_hit;

    // field add: returns {carry, new word}; other bits of the word pass untouched
    function automatic logic [32:0] fld_add(input logic [31:0] w, input logic [4:0] lsb,
                                            input logic [5:0] wid, input logic [15:0] amt);
        logic [32:0] mask;
        logic [32:0] fld;
        logic [32:0] sum;
        logic [31:0] mpos;
        mask = (33'h1 << wid) - 33'h1;
        fld  = ({1'b0, w} >> lsb) & mask;
        sum  = fld + {17'h0, amt};
        mpos = mask[31:0] << lsb;
        return {sum[wid], (w & ~mpos) | ((sum[31:0] << lsb) & mpos)};
    endfunction

    // lowest port with a pending discard
    function automatic logic [3:0] first_port(input logic [9:0] v);
        logic [3:0] p;
        p = 4'h0;
        for (int i = psc_pkg::NPORT - 1; i >= 0; i--) begin
            if (v[i]) begin
                p = 4'(i);
            end
        end
        return p;
    endfunction

    // one pass per event: read and rewrite all 16 words of the port
    always_comb begin
        upd_word = mif.upd_rdata;
        wrap_now = 30'h0;
        for (int b = 0; b < psc_pkg::NFLD; b++) begin
            logic [15:0] amt;
            logic [32:0] res;
            amt = 16'h0;
            res = 33'h0;
            if (inc_r[b]) begin
                amt = (b == psc_pkg::F_TX_BYTES) ? txb_r :
                      (b == psc_pkg::F_RX_BYTES || b == psc_pkg::F_RX_TOTB) ? rxb_r : 16'h1;
            end
            res = fld_add(upd_word, psc_pkg::FLD_LSB[b], psc_pkg::FLD_WID[b], amt);
            if (psc_pkg::FLD_WORD[b] == word_r) begin
                upd_word    = res[31:0];
                wrap_now[b] = res[32] && inc_r[b];
            end
        end
    end

    always_comb begin
        pend_any  = pend_filt_r | pend_dly_r;
        pend_port = first_port(pend_any);
        st_nxt        = st_r;
        port_nxt      = port_r;
        word_nxt      = word_r;
        inc_nxt       = inc_r;
        txb_nxt       = txb_r;
        rxb_nxt       = rxb_r;
        pend_filt_nxt = pend_filt_r;
        pend_dly_nxt  = pend_dly_r;
        case (st_r)
            psc_pkg::S_CLR: begin
                word_nxt = word_r + 4'h1;
                if (word_r == psc_pkg::LAST_WORD) begin
                    port_nxt = port_r + 4'h1;
                    if (port_r == psc_pkg::LAST_PORT) begin
                        st_nxt   = psc_pkg::S_IDLE;
                        port_nxt = 4'h0;
                    end
                end
            end
            psc_pkg::S_IDLE: begin
                word_nxt = 4'h0;
                if (mac_evt_vld && ctrl_en_r) begin
                    st_nxt   = psc_pkg::S_RD;
                    port_nxt = mac_evt_port;
                    inc_nxt  = mac_evt_inc;
                    inc_nxt[psc_pkg::F_SEND_FAIL] = mac_tx_underrun || mac_late_col
                                                    || mac_col16;
                    inc_nxt[psc_pkg::F_LATE_COL]  = mac_evt_inc[psc_pkg::F_LATE_COL]
                                                    || mac_late_col;
                    txb_nxt  = mac_tx_bytes;
                    rxb_nxt  = mac_rx_bytes;
                end else if (ctrl_en_r && pend_any != 10'h0) begin
                    st_nxt   = psc_pkg::S_RD;
                    port_nxt = pend_port;
                    inc_nxt  = 30'h0;
                end
                // discards fold into whichever pass visits their port
                if (st_nxt == psc_pkg::S_RD) begin
                    inc_nxt[psc_pkg::F_FILTER]   = pend_filt_r[port_nxt];
                    inc_nxt[psc_pkg::F_DLY_DISC] = pend_dly_r[port_nxt];
                    pend_filt_nxt[port_nxt] = 1'b0;
                    pend_dly_nxt[port_nxt]  = 1'b0;
                end
            end
            psc_pkg::S_RD: begin
                st_nxt = psc_pkg::S_WR;
            end
            psc_pkg::S_WR: begin
                word_nxt = word_r + 4'h1;
                st_nxt   = (word_r == psc_pkg::LAST_WORD) ? psc_pkg::S_IDLE : psc_pkg::S_RD;
            end
            default: begin
                st_nxt = psc_pkg::S_IDLE;
            end
        endcase
        // a new discard beats the clear of its pending bit
        if (qm_filt_vld && qm_filt_port <= psc_pkg::LAST_PORT) begin
            pend_filt_nxt[qm_filt_port] = 1'b1;
        end
        if (bm_dly_vld && bm_dly_port <= psc_pkg::LAST_PORT) begin
            pend_dly_nxt[bm_dly_port] = 1'b1;
        end
        rdy_nxt = (st_nxt == psc_pkg::S_IDLE);
    end

    // host side: control, wrap flags, interrupt
    always_comb begin
        ctrl_en_nxt = ctrl_en_r;
        flags_nxt   = flags_r;
        lport_nxt   = lport_r;
        if (reg_wr && reg_addr == psc_pkg::A_CTRL) begin
            ctrl_en_nxt = reg_wdata[psc_pkg::CTRL_EN_B];
        end
        if (reg_wr && reg_addr == psc_pkg::A_WRAP_LO) begin
            flags_nxt = flags_r & ~reg_wdata[29:0];
        end
        // set wins over a same-cycle clear
        if (st_r == psc_pkg::S_WR && wrap_now != 30'h0) begin
            flags_nxt = flags_nxt | wrap_now;
            lport_nxt = port_r;
        end
        irq_nxt = (flags_r != 30'h0);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r        <= psc_pkg::S_CLR;
            port_r      <= 4'h0;
            word_r      <= 4'h0;
            inc_r       <= 30'h0;
            txb_r       <= 16'h0;
            rxb_r       <= 16'h0;
            rdy_r       <= 1'b0;
            pend_filt_r <= 10'h0;
            pend_dly_r  <= 10'h0;
            flags_r     <= 30'h0;
            lport_r     <= 4'h0;
            ctrl_en_r   <= psc_pkg::CTRL_RST;
            irq_r       <= 1'b0;
        end else if (ce) begin
            st_r        <= st_nxt;
            port_r      <= port_nxt;
            word_r      <= word_nxt;
            inc_r       <= inc_nxt;
            txb_r       <= txb_nxt;
            rxb_r       <= rxb_nxt;
            rdy_r       <= rdy_nxt;
            pend_filt_r <= pend_filt_nxt;
            pend_dly_r  <= pend_dly_nxt;
            flags_r     <= flags_nxt;
            lport_r     <= lport_nxt;
            ctrl_en_r   <= ctrl_en_nxt;
            irq_r       <= irq_nxt;
        end
    end

    // memory hookup; clear sweep zeroes every counter after reset
    assign cnt_hit       = (reg_addr[11:10] == 2'h0) && (reg_addr[9:6] <= psc_pkg::LAST_PORT);
    assign mif.upd_addr  = {port_r, word_r};
    assign mif.wr_en     = (st_r == psc_pkg::S_WR) || (st_r == psc_pkg::S_CLR);
    assign mif.wr_addr   = {port_r, word_r};
    assign mif.wr_data   = (st_r == psc_pkg::S_CLR) ? 32'h0 : upd_word;
    assign mif.host_rd   = reg_rd;
    assign mif.host_addr = reg_addr[9:2];
    assign mif.alt_sel   = !cnt_hit;
    assign mif.alt_data  = (reg_addr == psc_pkg::A_CTRL)    ? {31'h0, ctrl_en_r} :
                           (reg_addr == psc_pkg::A_WRAP_LO) ? {2'h0, flags_r} :
                           (reg_addr == psc_pkg::A_WRAP_HI) ? {28'h0, lport_r} : 32'h0;

    psc_mem u_mem (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .m     (mif.mem)
    );

    assign reg_rdata   = mif.host_rdata;
    assign mac_evt_rdy = rdy_r;
    // bits 33..30 carry the port that last wrapped, bits 63..34 are zero
    assign wrap_word   = {30'h0, lport_r, flags_r};
    assign wrap_irq    = irq_r;

    // flag groups: follow the package field table by bit position

    a_wrap_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && st_r == psc_pkg::S_WR && wrap_now != 30'h0)
        |=> ((flags_r & $past(wrap_now)) == $past(wrap_now)))
        else $error("wrap did not set its flag");

    a_irq_follows: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && flags_r != 30'h0) |=> wrap_irq)
        else $error("wrap flag without interrupt");

    a_dword_rolls: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r == psc_pkg::S_WR && word_r == 4'h0 && wrap_now[0]) |-> (mif.wr_data < 32'(txb_r)))
        else $error("full-word counter did not roll over");

    a_idle_word_kept: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r == psc_pkg::S_WR && word_r == 4'h1 && !inc_r[1])
        |-> (mif.wr_data[23:0] == mif.upd_rdata[23:0]))
        else $error("carry leaked into an idle field");

    a_set_beats_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && reg_wr && reg_addr == psc_pkg::A_WRAP_LO && st_r == psc_pkg::S_WR && wrap_now[0])
        |=> wrap_word[0])
        else $error("clear beat a wrap");

    a_fail_sources: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && st_r == psc_pkg::S_IDLE && ctrl_en_r && mac_evt_vld && mac_col16)
        |=> inc_r[psc_pkg::F_SEND_FAIL])
        else $error("sixteen collisions not counted as send fail");

    a_filt_pending: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && qm_filt_vld && qm_filt_port == 4'h3) |=> pend_filt_r[3])
        else $error("filter event lost");

    a_pass_length: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        (st_r == psc_pkg::S_IDLE && ctrl_en_r && mac_evt_vld)
        |=> !mac_evt_rdy ##32 mac_evt_rdy)
        else $error("update pass length wrong");

endmodule

// *** dv/psc_mac_model.sv ***
`timescale 1ns/1ns
// far-side MAC: raises an event and holds it until the block shows ready, even if counting is disabled and the block does not take it
module psc_mac_model (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // bench request
    input  wire logic        go,
    input  wire logic [3:0]  port_in,
    input  wire logic [29:0] inc_in,
    input  wire logic [15:0] bytes_in,
    input  wire logic [2:0]  err_in,
    // event port
    input  wire logic        mac_evt_rdy,
    output logic             mac_evt_vld,
    output logic [3:0]       mac_evt_port,
    output logic [29:0]      mac_evt_inc,
    output logic [15:0]      mac_tx_bytes,
    output logic [15:0]      mac_rx_bytes,
    output logic [2:0]       mac_err
);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mac_evt_vld <= 1'b0;
            mac_evt_port <= 4'h0;
            mac_evt_inc <= 30'h0;
            mac_tx_bytes <= 16'h0;
            mac_rx_bytes <= 16'h0;
            mac_err <= 3'h0;
        end else if (go) begin
            mac_evt_vld <= 1'b1;
            mac_evt_port <= port_in;
            mac_evt_inc <= inc_in;
            mac_tx_bytes <= bytes_in;
            mac_rx_bytes <= {bytes_in[14:0], 1'b0};
            mac_err <= err_in;
        end else if (mac_evt_vld && mac_evt_rdy) begin
            // released fields turn over so a late sample cannot pass
            mac_evt_vld <= 1'b0;
            mac_evt_port <= ~mac_evt_port;
            mac_evt_inc <= ~mac_evt_inc;
            mac_tx_bytes <= ~mac_tx_bytes;
            mac_rx_bytes <= ~mac_rx_bytes;
            mac_err <= ~mac_err;
        end
    end
endmodule

// *** dv/test_port_statistics_counters.sv ***
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module test_port_statistics_counters;
    logic        mclk, rst_n, reg_wr, reg_rd, go, mac_evt_vld, mac_evt_rdy, wrap_irq;
    logic        bm_dly_vld, qm_filt_vld, ce;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_v;
    logic [3:0]  bm_dly_port, qm_filt_port, port_in, mac_evt_port;
    logic [29:0] inc_in, mac_evt_inc;
    logic [15:0] bytes_in, mac_tx_bytes, mac_rx_bytes;
    logic [2:0]  err_in, mac_err;
    logic [63:0] wrap_word;
    logic [31:0] exp_a [16];
    int          mismatches, checks, i;

    psc_top i_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mac_evt_vld(mac_evt_vld), .mac_evt_port(mac_evt_port), .mac_evt_inc(mac_evt_inc),
        .mac_tx_bytes(mac_tx_bytes), .mac_rx_bytes(mac_rx_bytes),
        .mac_tx_underrun(mac_err[0]), .mac_late_col(mac_err[1]), .mac_col16(mac_err[2]),
        .mac_evt_rdy(mac_evt_rdy), .bm_dly_vld(bm_dly_vld), .bm_dly_port(bm_dly_port),
        .qm_filt_vld(qm_filt_vld), .qm_filt_port(qm_filt_port), .wrap_word(wrap_word),
        .wrap_irq(wrap_irq));

    psc_mac_model i_mac (.mclk(mclk), .rst_n(rst_n), .go(go), .port_in(port_in),
        .inc_in(inc_in), .bytes_in(bytes_in), .err_in(err_in), .mac_evt_rdy(mac_evt_rdy),
        .mac_evt_vld(mac_evt_vld), .mac_evt_port(mac_evt_port), .mac_evt_inc(mac_evt_inc),
        .mac_tx_bytes(mac_tx_bytes), .mac_rx_bytes(mac_rx_bytes), .mac_err(mac_err));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task print_verdict;
        if (mismatches == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    function logic [11:0] ca(input logic [3:0] p, input logic [3:0] w);
        return {p, w, 2'b00};
    endfunction

    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [11:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask

    // bounded wait for the event port to settle back to idle
    task wait_idle;
        int n;
        n = 0;
        @(posedge mclk);
        #1;
        while (!(mac_evt_vld === 1'b0 && mac_evt_rdy === 1'b1)) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 400) begin
                mismatches++;
                print_verdict;
            end
        end
    endtask

    task evt(input logic [3:0] p, input logic [29:0] inc, input logic [2:0] e);
        @(posedge mclk);
        go <= 1'b1;
        port_in <= p;
        inc_in <= inc;
        err_in <= e;
        @(posedge mclk);
        go <= 1'b0;
        wait_idle;
    endtask

    initial begin
        // one event with every mac counter bit except late collision, tx 0x10 and rx 0x20 bytes
        exp_a = '{32'h10, 32'h01000001, 32'h00010001, 32'h20, 32'h1, 32'h20,
                  32'h01000001, 32'h00010001, 32'h01000001, 32'h01000001, 32'h00010001,
                  32'h00010001, 32'h01010001, 32'h00010001, 32'h00010001, 32'h0};
        {rst_n, reg_wr, reg_rd, go, bm_dly_vld, qm_filt_vld} = 6'h0;
        {reg_addr, reg_wdata, port_in, inc_in, err_in} = '0;
        {bm_dly_port, qm_filt_port} = 8'h0;
        bytes_in = 16'h0010;
        ce = 1'b1;
        mismatches = 0;
        checks = 0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        wait_idle;
        rd(psc_pkg::A_CTRL);
        `CHK("ctrl reset", 32'h1, rd_v)
        rd(12'h40c);
        `CHK("unmapped", 32'h0, rd_v)
        rd(psc_pkg::A_WRAP_LO);
        `CHK("wrap lo reset", 32'h0, rd_v)
        evt(4'h3, 30'h07ff_fffb, 3'b001);
        for (i = 0; i < 16; i++) begin
            rd(ca(4'h3, i[3:0]));
            `CHK("counter word", exp_a[i], rd_v)
        end
        rd(ca(4'h2, 4'h1));
        `CHK("other port", 32'h0, rd_v)
        `CHK("no wrap", 64'h0, wrap_word)
        // both discard sources on one port in the same cycle
        @(posedge mclk);
        {bm_dly_vld, qm_filt_vld} <= 2'b11;
        {bm_dly_port, qm_filt_port} <= 8'h33;
        @(posedge mclk);
        {bm_dly_vld, qm_filt_vld} <= 2'b00;
        repeat (4) @(posedge mclk);
        wait_idle;
        evt(4'h3, 30'h0, 3'b100);
        evt(4'h3, 30'h0, 3'b010);
        rd(ca(4'h3, 4'hf));
        `CHK("discard word", 32'h01010001, rd_v)
        rd(ca(4'h3, 4'h1));
        `CHK("send fail", 32'h03000001, rd_v)
        // middle byte field wraps beside a 16-bit field in the same word
        for (i = 0; i < 256; i++) begin
            evt(4'h5, 30'h0030_0000, 3'b000);
        end
        rd(ca(4'h5, 4'hc));
        `CHK("wrapped word", 32'h00000100, rd_v)
        `CHK("wrap word", {30'h0, 4'h5, 30'h0020_0000}, wrap_word)
        `CHK("wrap irq", 1'b1, wrap_irq)
        rd(psc_pkg::A_WRAP_HI);
        `CHK("wrap hi", 32'h5, rd_v)
        wr(psc_pkg::A_WRAP_LO, 32'h0020_0000);
        repeat (3) @(posedge mclk);
        #1;
        `CHK("flags cleared", 30'h0, wrap_word[29:0])
        `CHK("irq cleared", 1'b0, wrap_irq)
        // counting disabled; counter space is not writable
        wr(psc_pkg::A_CTRL, 32'h0);
        wr(ca(4'h5, 4'hc), 32'hffff_ffff);
        evt(4'h5, 30'h0010_0000, 3'b000);
        rd(ca(4'h5, 4'hc));
        `CHK("frozen word", 32'h00000100, rd_v)
        rd(psc_pkg::A_CTRL);
        `CHK("ctrl off", 32'h0, rd_v)
        wr(psc_pkg::A_CTRL, 32'h1);
        evt(4'h5, 30'h0010_0000, 3'b000);
        rd(ca(4'h5, 4'hc));
        `CHK("counting again", 32'h00000101, rd_v)
        // enable low: a write in that cycle must not land
        @(posedge mclk);
        ce <= 1'b0;
        wr(psc_pkg::A_CTRL, 32'h0);
        ce <= 1'b1;
        rd(psc_pkg::A_CTRL);
        `CHK("ce frozen ctrl", 32'h1, rd_v)
        print_verdict;
    end
endmodule
